// file: rtl/esd_decoder.sv
// extension space decoder: one registered decode stage
// assumes INSTR and the version straps come from logic on CLOCK
//
// How it works
// RL1: permanently undefined pattern always decodes undefined
// RL2: coprocessor extension space is 11000, bit21 zero
// RL3: older or non-dsp cores: extension space undefined
// RL4: direct undefined exception is one rejection option
// RL5: else coprocessors must ignore undefined extension instructions
// RL6: dsp cores: bit22 clear still undefined
// RL7: dsp cores: bit22 set is double transfer
// RL8: v5 up: all-ones condition takes unconditional path
// RL9: unconditional instructions gated by architecture version
// RL10: preload select bit: immediate or register offset
// RL11: 101 pattern is branch-link-exchange, halfword bit
// RL12: processor-state change fields decoded from instruction
`timescale 1ns/10ps
`default_nettype none
module esd_decoder
  import esd_pkg::*;
#(
  parameter bit REJECT_DIRECT = 1'b1
)(
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic INSTR_VALID,
  input wire logic [INSTR_W-1:0] INSTR,
  input wire logic [1:0] VERSION,
  input wire logic ENH_DSP,
  input wire logic DSP_NO_PAIR,
  output logic DEC_VALID,
  output logic UNDEF,
  output logic TAKE_UNDEF,
  output logic CP_INHIBIT,
  output logic CP_EXT_SPACE,
  output logic CP_DOUBLE,
  output logic CP_TO_CORE,
  output logic UNCOND,
  output var esd_op_t OP,
  output logic REG_OFFSET,
  output logic HALF_BIT,
  output logic [OFS_HI:0] BRANCH_OFFSET,
  output logic [1:0] IMASK_ACT,
  output logic MODE_CHANGE,
  output logic [2:0] MASK_SEL,
  output logic [MODE_HI:0] TARGET_MODE,
  output logic [3:0] COPRO_NUM,
  output logic [3:0] BASE_REG
);
  esd_op_t uop;
  logic perm;
  logic uncond;
  logic cp_space;
  logic cp_dbl_ok;
  logic undef;
  logic next_valid;
  logic next_undef;
  logic next_take;
  logic next_inhibit;
  logic next_cp_space;
  logic next_cp_double;
  logic next_cp_to_core;
  logic next_uncond;
  esd_op_t next_op;

  // unconditional space decode lives in its own leaf
  esd_uncond_decode u_uncond (
    .instr(INSTR),
    .version(VERSION),
    .enh_dsp(ENH_DSP),
    .dsp_no_pair(DSP_NO_PAIR),
    .op(uop)
  );

  // classification of the current word
  always_comb begin
    perm = (INSTR[OP1_HI:OP1_LO] == PERM_OP1) && (INSTR[OP2_HI:OP2_LO] == PERM_OP2); // RL1
    uncond = (INSTR[COND_HI:COND_LO] == COND_UNCOND) && (VERSION >= VER_5); // RL8
    // under v4 the all-ones condition is left to condition evaluation
    cp_space = !uncond && (INSTR[CPX_HI:CPX_LO] == CPX_TAG) && !INSTR[CPX_ZERO_BIT]; // RL2
    cp_dbl_ok = (VERSION >= VER_5) && ENH_DSP && INSTR[DBL_BIT]; // RL3 RL6 RL7
    undef = perm || (cp_space && !cp_dbl_ok) || (uncond && (uop == OP_NONE)); // RL1 RL3 RL6
    next_valid = INSTR_VALID;
    next_undef = INSTR_VALID && undef;
    // rejection scheme chosen at build time, not per instruction
    next_take = INSTR_VALID && undef && REJECT_DIRECT; // RL4
    next_inhibit = INSTR_VALID && undef && cp_space && !REJECT_DIRECT; // RL5
    next_cp_space = INSTR_VALID && cp_space;
    next_cp_double = INSTR_VALID && cp_space && cp_dbl_ok && !perm; // RL7
    next_cp_to_core = INSTR_VALID && INSTR[DIR_BIT]; // RL7
    next_uncond = INSTR_VALID && uncond;
    next_op = (INSTR_VALID && uncond && !perm) ? uop : OP_NONE; // RL1 RL9
  end

  // class flags; cleared while nothing is offered so no stale decode lingers
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      DEC_VALID <= 1'b0;
      UNDEF <= 1'b0;
      TAKE_UNDEF <= 1'b0;
      CP_INHIBIT <= 1'b0;
      CP_EXT_SPACE <= 1'b0;
      CP_DOUBLE <= 1'b0;
      CP_TO_CORE <= 1'b0;
      UNCOND <= 1'b0;
      OP <= OP_NONE;
    end else begin
      DEC_VALID <= next_valid;
      UNDEF <= next_undef;
      TAKE_UNDEF <= next_take;
      CP_INHIBIT <= next_inhibit;
      CP_EXT_SPACE <= next_cp_space;
      CP_DOUBLE <= next_cp_double;
      CP_TO_CORE <= next_cp_to_core;
      UNCOND <= next_uncond;
      OP <= next_op;
    end
  end

  logic next_reg_offset;
  logic next_half;
  logic [OFS_HI:0] next_bofs;
  logic [1:0] next_imask;
  logic [0:0] next_mchg;
  logic [2:0] next_masksel;
  logic [MODE_HI:0] next_mode;
  logic [3:0] next_cpn;
  logic [3:0] next_base;

  // operand fields; held when idle to save toggling on the wide offset
  always_comb begin
    next_reg_offset = REG_OFFSET;
    next_half = HALF_BIT;
    next_bofs = BRANCH_OFFSET;
    next_imask = IMASK_ACT;
    next_mchg = MODE_CHANGE;
    next_masksel = MASK_SEL;
    next_mode = TARGET_MODE;
    next_cpn = COPRO_NUM;
    next_base = BASE_REG;
    if (INSTR_VALID) begin
      next_reg_offset = INSTR[XSEL_BIT]; // RL10
      next_half = INSTR[HALF_BIT_POS]; // RL11
      next_bofs = INSTR[OFS_HI:0]; // RL11
      next_imask = INSTR[IMOD_HI:IMOD_LO]; // RL12
      next_mchg = INSTR[MCHG_BIT]; // RL12
      next_masksel = INSTR[AIF_HI:AIF_LO]; // RL12
      next_mode = INSTR[MODE_HI:0]; // RL12
      next_cpn = INSTR[CPN_HI:CPN_LO];
      next_base = INSTR[BASE_HI:BASE_LO];
    end
  end

  // operand field registers
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      REG_OFFSET <= 1'b0;
      HALF_BIT <= 1'b0;
      BRANCH_OFFSET <= '0;
      IMASK_ACT <= 2'h0;
      MODE_CHANGE <= 1'b0;
      MASK_SEL <= 3'h0;
      TARGET_MODE <= '0;
      COPRO_NUM <= 4'h0;
      BASE_REG <= 4'h0;
    end else begin
      REG_OFFSET <= next_reg_offset;
      HALF_BIT <= next_half;
      BRANCH_OFFSET <= next_bofs;
      IMASK_ACT <= next_imask;
      MODE_CHANGE <= next_mchg;
      MASK_SEL <= next_masksel;
      TARGET_MODE <= next_mode;
      COPRO_NUM <= next_cpn;
      BASE_REG <= next_base;
    end
  end

  // checks on the decode stage, one cycle from word to answer
  perm_undef_a: assert property (@(posedge CLOCK) disable iff (!ARST_N) // RL1
    INSTR_VALID && INSTR[OP1_HI:OP1_LO] == PERM_OP1 && INSTR[OP2_HI:OP2_LO] == PERM_OP2
    |=> UNDEF && OP == OP_NONE && !CP_DOUBLE)
    else $error("permanent undefined word decoded as defined");
  cp_space_a: assert property (@(posedge CLOCK) disable iff (!ARST_N) // RL2
    INSTR_VALID && INSTR[COND_HI:COND_LO] != COND_UNCOND && INSTR[CPX_HI:CPX_LO] == CPX_TAG
    && !INSTR[CPX_ZERO_BIT] |=> CP_EXT_SPACE)
    else $error("coprocessor extension space missed");
  legacy_cp_a: assert property (@(posedge CLOCK) disable iff (!ARST_N) // RL3
    CP_EXT_SPACE && ($past(VERSION) == VER_4 || !$past(ENH_DSP)) |-> UNDEF && !CP_DOUBLE)
    else $error("extension space defined on older core");
  direct_reject_a: assert property (@(posedge CLOCK) disable iff (!ARST_N) // RL4
    TAKE_UNDEF == (UNDEF && REJECT_DIRECT))
    else $error("direct undefined exception mismatch");
  copro_inhibit_a: assert property (@(posedge CLOCK) disable iff (!ARST_N) // RL5
    (UNDEF && CP_EXT_SPACE && !REJECT_DIRECT) |-> CP_INHIBIT && !TAKE_UNDEF)
    else $error("coprocessors not told to ignore undefined word");
  bit22_clear_a: assert property (@(posedge CLOCK) disable iff (!ARST_N) // RL6
    CP_EXT_SPACE && !$past(INSTR[DBL_BIT]) |-> UNDEF && !CP_DOUBLE)
    else $error("bit22 clear extension word not undefined");
  double_xfer_a: assert property (@(posedge CLOCK) disable iff (!ARST_N) // RL7
    CP_EXT_SPACE && $past(INSTR[DBL_BIT]) && $past(ENH_DSP) && $past(VERSION) != VER_4
    |-> CP_DOUBLE && !UNDEF && CP_TO_CORE == $past(INSTR[DIR_BIT]))
    else $error("double transfer decode wrong");
  uncond_route_a: assert property (@(posedge CLOCK) disable iff (!ARST_N) // RL8
    DEC_VALID |-> UNCOND == ($past(INSTR[COND_HI:COND_LO]) == COND_UNCOND
    && $past(VERSION) != VER_4))
    else $error("unconditional routing wrong");
  version_gate_a: assert property (@(posedge CLOCK) disable iff (!ARST_N) // RL9
    (OP == OP_CHANGE_PROC_STATE || OP == OP_SET_BYTE_ORDER || OP == OP_SAVE_RETURN_STATE
    || OP == OP_RETURN_FROM_EXC || OP == OP_COPRO_DOUBLE_READ_ALT
    || OP == OP_COPRO_DOUBLE_WRITE_ALT) |-> $past(VERSION) >= VER_6)
    else $error("version six operation allowed on older core");
  preload_gate_a: assert property (@(posedge CLOCK) disable iff (!ARST_N) // RL9
    OP == OP_CACHE_PRELOAD |-> $past(ENH_DSP) && !$past(DSP_NO_PAIR) && !UNDEF)
    else $error("preload allowed without dsp variant");
  preload_sel_a: assert property (@(posedge CLOCK) disable iff (!ARST_N) // RL10
    OP == OP_CACHE_PRELOAD |-> REG_OFFSET == $past(INSTR[XSEL_BIT]))
    else $error("preload offset select wrong");
  branch_fields_a: assert property (@(posedge CLOCK) disable iff (!ARST_N) // RL11
    OP == OP_BRANCH_LINK_EXCHANGE |-> HALF_BIT == $past(INSTR[HALF_BIT_POS])
    && BRANCH_OFFSET == $past(INSTR[OFS_HI:0]) && $past(VERSION) >= VER_5)
    else $error("branch-link-exchange fields wrong");
  state_fields_a: assert property (@(posedge CLOCK) disable iff (!ARST_N) // RL12
    OP == OP_CHANGE_PROC_STATE |-> IMASK_ACT == $past(INSTR[IMOD_HI:IMOD_LO])
    && MODE_CHANGE == $past(INSTR[MCHG_BIT])
    && MASK_SEL == $past(INSTR[AIF_HI:AIF_LO]) && TARGET_MODE == $past(INSTR[MODE_HI:0]))
    else $error("processor-state change fields wrong");
endmodule // esd_decoder
`default_nettype wire

// file: rtl/esd_pkg.sv
// constants for the extension space decoder
// assumes one core clock; instruction words arrive from the fetch stage
package esd_pkg;
  localparam int INSTR_W = 32;
  // architecture version codes
  localparam logic [1:0] VER_4 = 2'h0;
  localparam logic [1:0] VER_5 = 2'h1;
  localparam logic [1:0] VER_6 = 2'h2;
  // field positions
  localparam int COND_HI = 31;
  localparam int COND_LO = 28;
  localparam int OP1_HI = 27;
  localparam int OP1_LO = 20;
  localparam int OP2_HI = 7;
  localparam int OP2_LO = 4;
  localparam int CPX_HI = 27;
  localparam int CPX_LO = 23;
  localparam int DBL_BIT = 22;
  localparam int CPX_ZERO_BIT = 21;
  localparam int DIR_BIT = 20;
  localparam int XSEL_BIT = 25;
  localparam int HALF_BIT_POS = 24;
  localparam int OFS_HI = 23;
  localparam int IMOD_HI = 19;
  localparam int IMOD_LO = 18;
  localparam int MCHG_BIT = 17;
  localparam int BASE_HI = 19;
  localparam int BASE_LO = 16;
  localparam int CPN_HI = 11;
  localparam int CPN_LO = 8;
  localparam int AIF_HI = 8;
  localparam int AIF_LO = 6;
  localparam int MODE_HI = 4;
  // match values
  localparam logic [3:0] COND_UNCOND = 4'hf;
  localparam logic [7:0] PERM_OP1 = 8'h7f;
  localparam logic [3:0] PERM_OP2 = 4'hf;
  localparam logic [4:0] CPX_TAG = 5'h18;
  // mask and value pairs for the unconditional space
  localparam logic [31:0] M_STATE = 32'h0ff10000;
  localparam logic [31:0] V_STATE = 32'h01000000;
  localparam logic [31:0] M_ORDER = 32'h0ffff0f0;
  localparam logic [31:0] V_ORDER = 32'h01010000;
  localparam logic [31:0] M_PRELOAD = 32'h0d70f000;
  localparam logic [31:0] V_PRELOAD = 32'h0550f000;
  localparam logic [31:0] M_SAVE = 32'h0e500000;
  localparam logic [31:0] V_SAVE = 32'h08400000;
  localparam logic [31:0] V_RETURN = 32'h08100000;
  localparam logic [31:0] M_BRANCH = 32'h0e000000;
  localparam logic [31:0] V_BRANCH = 32'h0a000000;
  localparam logic [31:0] M_DBL = 32'h0fe00000;
  localparam logic [31:0] V_DBL = 32'h0c400000;
  localparam logic [31:0] V_LDST = 32'h0c000000;
  localparam logic [31:0] M_CDP = 32'h0f000010;
  localparam logic [31:0] V_CDP = 32'h0e000000;
  localparam logic [31:0] V_MOVE = 32'h0e000010;
  // decoded operation of the unconditional space
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_CHANGE_PROC_STATE = 4'h1,
    OP_SET_BYTE_ORDER = 4'h2,
    OP_CACHE_PRELOAD = 4'h3,
    OP_SAVE_RETURN_STATE = 4'h4,
    OP_RETURN_FROM_EXC = 4'h5,
    OP_BRANCH_LINK_EXCHANGE = 4'h6,
    OP_COPRO_DOUBLE_WRITE_ALT = 4'h7,
    OP_COPRO_DOUBLE_READ_ALT = 4'h8,
    OP_COPRO_STORE_ALT = 4'h9,
    OP_COPRO_LOAD_ALT = 4'ha,
    OP_COPRO_DATAOP_ALT = 4'hb,
    OP_COPRO_WRITE_ALT = 4'hc,
    OP_COPRO_READ_ALT = 4'hd
  } esd_op_t;
endpackage

// file: rtl/esd_uncond_decode.sv
// combinational decode of the unconditional space with version gating
// assumes the caller has already found the condition field all ones
`timescale 1ns/10ps
`default_nettype none
module esd_uncond_decode
  import esd_pkg::*;
(
  input wire logic [INSTR_W-1:0] instr,
  input wire logic [1:0] version,
  input wire logic enh_dsp,
  input wire logic dsp_no_pair,
  output var esd_op_t op
);
  esd_op_t raw;
  logic v5;
  logic v6;

  // pattern match, most specific first so the double transfer beats load/store
  always_comb begin
    raw = OP_NONE;
    if ((instr & M_STATE) == V_STATE) begin
      raw = OP_CHANGE_PROC_STATE;
    end else if ((instr & M_ORDER) == V_ORDER) begin
      raw = OP_SET_BYTE_ORDER;
    end else if ((instr & M_PRELOAD) == V_PRELOAD) begin
      raw = OP_CACHE_PRELOAD;
    end else if ((instr & M_SAVE) == V_SAVE) begin
      raw = OP_SAVE_RETURN_STATE;
    end else if ((instr & M_SAVE) == V_RETURN) begin
      raw = OP_RETURN_FROM_EXC;
    end else if ((instr & M_BRANCH) == V_BRANCH) begin
      raw = OP_BRANCH_LINK_EXCHANGE; // RL11
    end else if ((instr & M_DBL) == V_DBL) begin
      raw = instr[DIR_BIT] ? OP_COPRO_DOUBLE_READ_ALT : OP_COPRO_DOUBLE_WRITE_ALT;
    end else if ((instr & M_BRANCH) == V_LDST) begin
      raw = instr[DIR_BIT] ? OP_COPRO_LOAD_ALT : OP_COPRO_STORE_ALT;
    end else if ((instr & M_CDP) == V_CDP) begin
      raw = OP_COPRO_DATAOP_ALT;
    end else if ((instr & M_CDP) == V_MOVE) begin
      raw = instr[DIR_BIT] ? OP_COPRO_READ_ALT : OP_COPRO_WRITE_ALT;
    end
  end

  // version gate; an op the core lacks falls back to undefined
  always_comb begin
    v5 = (version >= VER_5);
    v6 = (version >= VER_6);
    op = OP_NONE;
    case (raw)
      OP_BRANCH_LINK_EXCHANGE, OP_COPRO_STORE_ALT, OP_COPRO_LOAD_ALT,
      OP_COPRO_DATAOP_ALT, OP_COPRO_WRITE_ALT, OP_COPRO_READ_ALT: begin
        op = v5 ? raw : OP_NONE; // RL9
      end
      OP_CHANGE_PROC_STATE, OP_SET_BYTE_ORDER, OP_SAVE_RETURN_STATE,
      OP_RETURN_FROM_EXC, OP_COPRO_DOUBLE_WRITE_ALT, OP_COPRO_DOUBLE_READ_ALT: begin
        op = v6 ? raw : OP_NONE; // RL9
      end
      OP_CACHE_PRELOAD: begin
        // the paired-transfer-less dsp variant has no preload
        op = (v5 && enh_dsp && !dsp_no_pair) ? raw : OP_NONE; // RL9
      end
      default: begin
        op = OP_NONE;
      end
    endcase
  end
endmodule // esd_uncond_decode
`default_nettype wire

// file: sim/esd_copro_model.sv
// attached coprocessor model for the extension space decoder
// assumes it watches the decode stage of a decoder in the inhibit scheme
`timescale 1ns/10ps
`default_nettype none
module esd_copro_model (
  input wire logic dec_valid,
  input wire logic cp_ext_space,
  input wire logic cp_inhibit,
  output logic accept
);
  // takes any extension word unless told to stay quiet; never looks at the kind
  assign accept = dec_valid && cp_ext_space && !cp_inhibit;
endmodule // esd_copro_model
`default_nettype wire

// file: sim/extension_space_decoder_tb.sv
// self-checking bench for esd_decoder, both rejection schemes side by side
// assumes one core clock; inputs driven on the falling edge
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module extension_space_decoder_tb;
  import esd_pkg::*;
  logic clk, arst_n, iv, e, n, dv, ud, tk, ih, cx, db, tc, uc, rg, hb, mc;
  logic ud2, tk2, ih2, dv2, cx2, acc, exp_acc;
  logic [31:0] w, seed, rw;
  logic [1:0] ver, im;
  logic [23:0] bo;
  logic [2:0] ms;
  logic [4:0] tm;
  logic [3:0] cn, br;
  logic [7:0] exp_cls;
  logic [1:0] exp_inh;
  logic [44:0] exp_fld;
  esd_op_t op, exp_op;
  int mismatches, tests_run;
  logic [31:0] tab [21] = '{32'he7f000f0, 32'hec500000, 32'hec400000, 32'hec000000,
    32'hfa000005, 32'hfb123456, 32'hf1080011, 32'hf1010200, 32'hf5d0f000, 32'hf7d0f001,
    32'hf84d0500, 32'hf8100a00, 32'hfc500000, 32'hfc400000, 32'hfc000000, 32'hfd100000,
    32'hfe000000, 32'hfe100010, 32'hff000000, 32'hfe000010, 32'hf7f000f0};
  esd_decoder #(.REJECT_DIRECT(1'b1)) u_esd_decoder (.CLOCK(clk), .ARST_N(arst_n),
    .INSTR_VALID(iv), .INSTR(w), .VERSION(ver), .ENH_DSP(e), .DSP_NO_PAIR(n),
    .DEC_VALID(dv), .UNDEF(ud), .TAKE_UNDEF(tk), .CP_INHIBIT(ih), .CP_EXT_SPACE(cx),
    .CP_DOUBLE(db), .CP_TO_CORE(tc), .UNCOND(uc), .OP(op), .REG_OFFSET(rg), .HALF_BIT(hb),
    .BRANCH_OFFSET(bo), .IMASK_ACT(im), .MODE_CHANGE(mc), .MASK_SEL(ms),
    .TARGET_MODE(tm), .COPRO_NUM(cn), .BASE_REG(br));
  // second decoder in the inhibit scheme feeds the coprocessor model
  esd_decoder #(.REJECT_DIRECT(1'b0)) u_esd_decoder_inh (.CLOCK(clk), .ARST_N(arst_n),
    .INSTR_VALID(iv), .INSTR(w), .VERSION(ver), .ENH_DSP(e), .DSP_NO_PAIR(n),
    .DEC_VALID(dv2), .UNDEF(ud2), .TAKE_UNDEF(tk2), .CP_INHIBIT(ih2), .CP_EXT_SPACE(cx2),
    .CP_DOUBLE(), .CP_TO_CORE(), .UNCOND(), .OP(), .REG_OFFSET(), .HALF_BIT(),
    .BRANCH_OFFSET(), .IMASK_ACT(), .MODE_CHANGE(), .MASK_SEL(), .TARGET_MODE(),
    .COPRO_NUM(), .BASE_REG());
  esd_copro_model u_esd_copro_model (.dec_valid(dv2), .cp_ext_space(cx2),
    .cp_inhibit(ih2), .accept(acc));
  // expected unconditional op, version gated
  function automatic esd_op_t f_op(logic [31:0] x, logic [1:0] v, logic d, logic np);
    esd_op_t o;
    logic ok;
    o = OP_NONE;
    ok = 1'b0;
    if ((x & M_STATE) == V_STATE) begin o = OP_CHANGE_PROC_STATE; ok = v >= VER_6; end
    else if ((x & M_ORDER) == V_ORDER) begin o = OP_SET_BYTE_ORDER; ok = v >= VER_6; end
    else if ((x & M_PRELOAD) == V_PRELOAD) begin
      o = OP_CACHE_PRELOAD;
      ok = v >= VER_5 && d && !np;
    end
    else if ((x & M_SAVE) == V_SAVE) begin o = OP_SAVE_RETURN_STATE; ok = v >= VER_6; end
    else if ((x & M_SAVE) == V_RETURN) begin o = OP_RETURN_FROM_EXC; ok = v >= VER_6; end
    else if ((x & M_BRANCH) == V_BRANCH) begin o = OP_BRANCH_LINK_EXCHANGE; ok = v >= VER_5; end
    else if ((x & M_DBL) == V_DBL) begin
      o = x[20] ? OP_COPRO_DOUBLE_READ_ALT : OP_COPRO_DOUBLE_WRITE_ALT;
      ok = v >= VER_6;
    end else if ((x & M_BRANCH) == V_LDST) begin
      o = x[20] ? OP_COPRO_LOAD_ALT : OP_COPRO_STORE_ALT;
      ok = v >= VER_5;
    end else if ((x & M_CDP) == V_CDP) begin o = OP_COPRO_DATAOP_ALT; ok = v >= VER_5; end
    else if ((x & M_CDP) == V_MOVE) begin
      o = x[20] ? OP_COPRO_READ_ALT : OP_COPRO_WRITE_ALT;
      ok = v >= VER_5;
    end
    return ok ? o : OP_NONE;
  endfunction
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check();
    `CHK({dv, ud, tk, ih, cx, db, tc, uc}, exp_cls)
    `CHK({tk2, ih2}, exp_inh)
    `CHK(op, exp_op)
    `CHK({rg, hb, bo, im, mc, ms, tm, cn, br}, exp_fld)
    `CHK(acc, exp_acc)
  endtask
  // check the previous word's answer, then offer the next word
  task automatic drive(logic v, logic [31:0] x, logic [1:0] vr, logic d, logic np);
    logic unc, cpx, dbl, u;
    check();
    iv = v;
    w = x;
    ver = vr;
    e = d;
    n = np;
    unc = x[COND_HI:COND_LO] == COND_UNCOND && vr >= VER_5;
    cpx = !unc && x[CPX_HI:CPX_LO] == CPX_TAG && !x[CPX_ZERO_BIT];
    dbl = cpx && vr >= VER_5 && d && x[DBL_BIT];
    exp_op = v && unc ? f_op(x, vr, d, np) : OP_NONE;
    u = (x[OP1_HI:OP1_LO] == PERM_OP1 && x[OP2_HI:OP2_LO] == PERM_OP2) || (cpx && !dbl)
      || (unc && exp_op == OP_NONE);
    exp_cls = v ? {1'b1, u, u, 1'b0, cpx, dbl, x[DIR_BIT], unc} : 8'h00;
    exp_inh = v ? {1'b0, cpx && !dbl} : 2'h0;
    exp_acc = v && dbl;
    if (v) exp_fld = {x[25:24], x[23:0], x[19:17], x[8:6], x[4:0], x[11:8], x[19:16]};
    @(negedge clk);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // bound on the whole run
  initial begin
    #1000000;
    mismatches++;
    test_done();
  end
  initial begin
    {arst_n, iv, e, n, ver, w, exp_cls, exp_inh, exp_fld, exp_acc} = '0;
    exp_op = OP_NONE;
    seed = 32'h4e4d790b;
    repeat (10) @(negedge clk);
    arst_n = 1'b1;
    // every corner word under every version and variant, back to back
    for (int c = 0; c < 16; c++) begin
      foreach (tab[k]) drive(1'b1, tab[k], c[1:0], c[2], c[3]);
    end
    drive(1'b0, 32'h0, VER_6, 1'b1, 1'b0);
    // reset in mid-run clears everything, fields included
    check();
    arst_n = 1'b0;
    {exp_cls, exp_inh, exp_fld, exp_acc} = '0;
    exp_op = OP_NONE;
    @(negedge clk);
    check();
    arst_n = 1'b1;
    // random words steered into the extension spaces
    for (int i = 0; i < 3000; i++) begin
      // word built in rw so the instruction input changes once per cycle
      seed = lfsr(seed);
      rw = seed;
      seed = lfsr(seed);
      if (seed[0]) rw[31:28] = 4'hf;
      if (seed[1]) rw[27:23] = 5'h18;
      drive(seed[2] | seed[3], rw, seed[5:4], seed[6], seed[7]);
    end
    drive(1'b0, 32'h0, VER_4, 1'b0, 1'b0);
    check();
    test_done();
  end
endmodule // extension_space_decoder_tb
`default_nettype wire
